// *** logic/int_prio_pkg.sv ***
// package: register map, field layout and shared types of the interrupt priority block
package int_prio_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [3:0] IDX_PRIO_0 = 4'h0;
    localparam logic [3:0] IDX_PRIO_1 = 4'h1;
    localparam logic [3:0] IDX_PRIO_9 = 4'h9;
    localparam logic [3:0] IDX_CTRL = 4'hc;
    localparam logic [3:0] IDX_EVT_STATUS = 4'hd;
    localparam logic [3:0] IDX_EVT_MASK = 4'he;

    localparam logic [15:0] PRIO_0_WMASK = 16'h3c00;
    localparam logic [15:0] PRIO_1_WMASK = 16'h003f;
    localparam logic [15:0] PRIO_9_WMASK = 16'hffff;
    localparam logic [15:0] PRIO_RESET = 16'h0000;

    localparam int BKPT_LSB = 12;
    localparam int STEP_LSB = 10;
    localparam int RX_LSB = 4;
    localparam int TX_LSB = 2;
    localparam int TRACE_LSB = 0;
    localparam int PWMA_LSB = 14;
    localparam int PWMB_LSB = 12;
    localparam int TMRA2_LSB = 2;
    localparam int TMRA1_LSB = 0;

    localparam int CTRL_NEST_LSB = 13;
    localparam int CTRL_VEC_LSB = 6;
    localparam int CTRL_OFF_BIT = 5;
    localparam int CTRL_ONE_BIT = 4;
    localparam int CTRL_B_LVL_BIT = 3;
    localparam int CTRL_A_LVL_BIT = 2;
    localparam int CTRL_B_EDGE_BIT = 1;
    localparam int CTRL_A_EDGE_BIT = 0;

    // event bits: falling edge seen on pin a / pin b, service routine entered
    localparam int EVT_A_FALL = 0;
    localparam int EVT_B_FALL = 1;
    localparam int EVT_TAKEN = 2;
    localparam int EVT_W = 3;

    typedef struct packed {
        logic [1:0] nest_level;
        logic [6:0] vector;
    } taken_s;
endpackage : int_prio_pkg

// *** logic/interrupt_priority_control.sv ***
// interrupt priority register slice with wishbone slave and external pin sensing
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// R1: priority zero bits 15-14, 9-0 read zero
// R2: bits 13-12 set breakpoint level one to three
// R3: bits 11-10 set step counter level one to three
// R4: timer a channel 2 field codes disabled/levels 0-2
// R5: timer a channel 1 field codes disabled/levels 0-2
// R6: priority nine bits 15-14 pwm a fault level
// R7: priority nine bits 13-12 pwm b fault level
// R8: all priority registers reset to zero
// R9: control 14-13 capture nest level on entry
// R10: nest code gives lowest allowed nested level
// R11: control 12-6 hold last vector on entry
// R12: control bit 5 blocks all source levels and pin requests, not irq_o
// R13: control bit 4 reads one, ignores writes
// R14: control bits 3,2 show pin b, a levels
// R15: control bit 1 selects pin b edge sensing
// R16: low power forces pin b level sensing
// R17: control bit 0 does same for pin a
// R18: priority one holds three low level fields
module interrupt_priority_control
    import int_prio_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic ext_int_a_pin_i,
    input wire logic ext_int_b_pin_i,
    input wire logic low_power_i,
    input wire logic isr_enter_i,
    input wire logic [1:0] isr_nest_level_i,
    input wire logic [6:0] isr_vector_i,
    output logic [1:0] debug_breakpoint_level_o,
    output logic [1:0] debug_step_level_o,
    output logic [1:0] debug_rx_level_o,
    output logic [1:0] debug_tx_level_o,
    output logic [1:0] trace_buffer_level_o,
    output logic [2:0] timer_a_ch2_level_o,
    output logic [2:0] timer_a_ch1_level_o,
    output logic [2:0] pwm_a_fault_level_o,
    output logic [2:0] pwm_b_fault_level_o,
    output logic [3:0] min_nest_level_o,
    output logic ext_int_a_req_o,
    output logic ext_int_b_req_o,
    output logic global_int_off_o,
    output logic irq_o
);
    // ==========================================================
    // field decoding
    // 3-bit level: bit 2 enable, bits 1:0 level; code 00 disables.
    // base-0 sources map 01..11 to levels 0..2
    function automatic logic [2:0] base0_level(input logic [1:0] code);
        base0_level = (code == 2'h0) ? 3'h0 : {1'b1, 2'(code - 2'h1)};
    endfunction : base0_level

    // ==========================================================
    // registers
    logic [15:0] prio_0_reg;
    logic [15:0] prio_1_reg;
    logic [15:0] prio_9_reg;
    taken_s taken_reg;
    logic global_int_off_reg;
    logic ext_int_b_edge_sel_reg;
    logic ext_int_a_edge_sel_reg;
    logic [EVT_W-1:0] evt_status_reg;
    logic [EVT_W-1:0] evt_mask_reg;
    logic [1:0] a_sync_reg;
    logic [1:0] b_sync_reg;
    logic a_prev_reg;
    logic b_prev_reg;
    logic a_edge_pend_reg;
    logic b_edge_pend_reg;

    logic bus_req;
    logic wr_stb;
    logic [3:0] reg_idx;
    logic [15:0] wdata;
    logic [15:0] ctrl_view;
    logic [31:0] rdata;
    logic a_fall;
    logic b_fall;
    logic a_edge_mode;
    logic b_edge_mode;
    logic [EVT_W-1:0] evt_set;

    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_stb = bus_req && wb_we_i;
    assign reg_idx = wb_adr_i[5:2];
    // low lanes carry the 16-bit registers; each enabled lane writes its own byte
    assign wdata = {wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00, wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00};

    // ==========================================================
    // pin synchronisers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            a_sync_reg <= 2'h3;
            b_sync_reg <= 2'h3;
            a_prev_reg <= 1'b1;
            b_prev_reg <= 1'b1;
        end else begin
            a_sync_reg <= {a_sync_reg[0], ext_int_a_pin_i};
            b_sync_reg <= {b_sync_reg[0], ext_int_b_pin_i};
            a_prev_reg <= a_sync_reg[1];
            b_prev_reg <= b_sync_reg[1];
        end
    end

    assign a_fall = a_prev_reg && !a_sync_reg[1];
    assign b_fall = b_prev_reg && !b_sync_reg[1];
    assign b_edge_mode = ext_int_b_edge_sel_reg && !low_power_i; // see R16
    assign a_edge_mode = ext_int_a_edge_sel_reg && !low_power_i; // see R17

    // ==========================================================
    // write bus byte enables and write masks keep reserved bits zero in priority zero and one; the priority nine mask lets all 16 bits be written
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prio_0_reg <= PRIO_RESET; // see R8
            prio_1_reg <= PRIO_RESET; // see R8
            prio_9_reg <= PRIO_RESET; // see R8
        end else if (wr_stb && (wb_sel_i[1:0] != 2'h0)) begin
            unique case (reg_idx)
                IDX_PRIO_0: prio_0_reg <= (prio_0_reg & ~PRIO_0_WMASK)
                    | (wdata & PRIO_0_WMASK & {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}}); // see R1
                IDX_PRIO_1: prio_1_reg <= (prio_1_reg & ~PRIO_1_WMASK)
                    | (wdata & PRIO_1_WMASK & {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}}); // see R18
                IDX_PRIO_9: prio_9_reg <= (prio_9_reg & ~({{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}}))
                    | (wdata & PRIO_9_WMASK & {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}});
                default: begin
                end
            endcase
        end
    end

    // control register writable bits live in the low byte
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            global_int_off_reg <= 1'b0;
            ext_int_b_edge_sel_reg <= 1'b0;
            ext_int_a_edge_sel_reg <= 1'b0;
        end else if (wr_stb && wb_sel_i[0] && reg_idx == IDX_CTRL) begin
            global_int_off_reg <= wb_dat_i[CTRL_OFF_BIT]; // see R12
            ext_int_b_edge_sel_reg <= wb_dat_i[CTRL_B_EDGE_BIT]; // see R15
            ext_int_a_edge_sel_reg <= wb_dat_i[CTRL_A_EDGE_BIT]; // see R17
        end
    end

    // captured only on service routine entry, so a nested entry overwrites it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            taken_reg <= '0;
        end else if (isr_enter_i) begin
            taken_reg.nest_level <= isr_nest_level_i; // see R9
            taken_reg.vector <= isr_vector_i; // see R11
        end
    end

    // ==========================================================
    // edge latches for the pin requests; cleared when the routine is entered, unless a new fall on that pin comes in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            a_edge_pend_reg <= 1'b0;
            b_edge_pend_reg <= 1'b0;
        end else begin
            if (!a_edge_mode) begin
                a_edge_pend_reg <= 1'b0;
            end else if (a_fall) begin
                a_edge_pend_reg <= 1'b1;
            end else if (isr_enter_i) begin
                a_edge_pend_reg <= 1'b0;
            end
            if (!b_edge_mode) begin
                b_edge_pend_reg <= 1'b0;
            end else if (b_fall) begin
                b_edge_pend_reg <= 1'b1;
            end else if (isr_enter_i) begin
                b_edge_pend_reg <= 1'b0;
            end
        end
    end

    // ==========================================================
    // event status and mask; set wins over write-one-to-clear
    assign evt_set = {isr_enter_i, b_fall, a_fall};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evt_status_reg <= '0;
        end else if (wr_stb && wb_sel_i[0] && reg_idx == IDX_EVT_STATUS) begin
            evt_status_reg <= (evt_status_reg & ~wb_dat_i[EVT_W-1:0]) | evt_set;
        end else begin
            evt_status_reg <= evt_status_reg | evt_set;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evt_mask_reg <= '0;
        end else if (wr_stb && wb_sel_i[0] && reg_idx == IDX_EVT_MASK) begin
            evt_mask_reg <= wb_dat_i[EVT_W-1:0];
        end
    end

    // ==========================================================
    // read mux and ack: one wait-free cycle, answer in the cycle after the request
    always_comb begin
        ctrl_view = 16'h0000;
        ctrl_view[CTRL_NEST_LSB +: 2] = taken_reg.nest_level; // see R9
        ctrl_view[CTRL_VEC_LSB +: 7] = taken_reg.vector; // see R11
        ctrl_view[CTRL_OFF_BIT] = global_int_off_reg;
        ctrl_view[CTRL_ONE_BIT] = 1'b1; // see R13
        ctrl_view[CTRL_B_LVL_BIT] = b_sync_reg[1]; // see R14
        ctrl_view[CTRL_A_LVL_BIT] = a_sync_reg[1]; // see R14
        ctrl_view[CTRL_B_EDGE_BIT] = ext_int_b_edge_sel_reg;
        ctrl_view[CTRL_A_EDGE_BIT] = ext_int_a_edge_sel_reg;
        unique case (reg_idx)
            IDX_PRIO_0: rdata = {16'h0000, prio_0_reg};
            IDX_PRIO_1: rdata = {16'h0000, prio_1_reg};
            IDX_PRIO_9: rdata = {16'h0000, prio_9_reg};
            IDX_CTRL: rdata = {16'h0000, ctrl_view};
            IDX_EVT_STATUS: rdata = {29'h0000000, evt_status_reg};
            IDX_EVT_MASK: rdata = {29'h0000000, evt_mask_reg};
            default: rdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= (bus_req && !wb_we_i) ? rdata : 32'h00000000;
        end
    end

    // ==========================================================
    // level outputs toward the core arbiter; global off forces every source level and pin request off
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            debug_breakpoint_level_o <= 2'h0;
            debug_step_level_o <= 2'h0;
            debug_rx_level_o <= 2'h0;
            debug_tx_level_o <= 2'h0;
            trace_buffer_level_o <= 2'h0;
            timer_a_ch2_level_o <= 3'h0;
            timer_a_ch1_level_o <= 3'h0;
            pwm_a_fault_level_o <= 3'h0;
            pwm_b_fault_level_o <= 3'h0;
            min_nest_level_o <= 4'h1;
            ext_int_a_req_o <= 1'b0;
            ext_int_b_req_o <= 1'b0;
            global_int_off_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            // base-1 sources: the code is the level itself, 0 means disabled
            debug_breakpoint_level_o <= global_int_off_reg ? 2'h0 : prio_0_reg[BKPT_LSB +: 2]; // see R2
            debug_step_level_o <= global_int_off_reg ? 2'h0 : prio_0_reg[STEP_LSB +: 2]; // see R3
            debug_rx_level_o <= global_int_off_reg ? 2'h0 : prio_1_reg[RX_LSB +: 2]; // see R18
            debug_tx_level_o <= global_int_off_reg ? 2'h0 : prio_1_reg[TX_LSB +: 2]; // see R18
            trace_buffer_level_o <= global_int_off_reg ? 2'h0 : prio_1_reg[TRACE_LSB +: 2]; // see R18
            timer_a_ch2_level_o <= global_int_off_reg ? 3'h0 : base0_level(prio_9_reg[TMRA2_LSB +: 2]); // see R4
            timer_a_ch1_level_o <= global_int_off_reg ? 3'h0 : base0_level(prio_9_reg[TMRA1_LSB +: 2]); // see R5
            pwm_a_fault_level_o <= global_int_off_reg ? 3'h0 : base0_level(prio_9_reg[PWMA_LSB +: 2]); // see R6
            pwm_b_fault_level_o <= global_int_off_reg ? 3'h0 : base0_level(prio_9_reg[PWMB_LSB +: 2]); // see R7
            // thermometer of allowed nested levels 3..0
            min_nest_level_o <= 4'hf << taken_reg.nest_level; // see R10
            ext_int_a_req_o <= !global_int_off_reg && (a_edge_mode ? a_edge_pend_reg : !a_sync_reg[1]); // see R17
            ext_int_b_req_o <= !global_int_off_reg && (b_edge_mode ? b_edge_pend_reg : !b_sync_reg[1]); // see R15
            global_int_off_o <= global_int_off_reg; // see R12
            irq_o <= |(evt_status_reg & evt_mask_reg);
        end
    end
endmodule : interrupt_priority_control
`default_nettype wire

// *** test/int_prio_chk.sv ***
// checker: bus handshake, field mapping, capture and pin sensing properties
`timescale 1ns/1ns
`default_nettype none
module int_prio_chk
    import int_prio_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic ext_int_b_pin_i,
    input wire logic low_power_i,
    input wire logic isr_enter_i,
    input wire logic [1:0] isr_nest_level_i,
    input wire logic [1:0] debug_breakpoint_level_o,
    input wire logic [2:0] pwm_a_fault_level_o,
    input wire logic [3:0] min_nest_level_o,
    input wire logic ext_int_a_req_o,
    input wire logic ext_int_b_req_o,
    input wire logic global_int_off_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic taken;
    assign taken = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    function automatic logic [2:0] map3(input logic [1:0] c);
        return (c == 2'h0) ? 3'h0 : {1'b1, c - 2'h1};
    endfunction : map3
    // ==========================================
    // properties
    a_ack_follows: assert property (taken |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_prio0_reserved: assert property (
        wb_ack_o && !wb_we_i && wb_adr_i[5:2] == IDX_PRIO_0
        |-> wb_dat_o[15:14] == 2'h0 && wb_dat_o[9:0] == 10'h0)
        else $error("reserved bits read nonzero");
    a_ctrl_one_bit: assert property (
        wb_ack_o && !wb_we_i && wb_adr_i[5:2] == IDX_CTRL |-> wb_dat_o[4])
        else $error("control bit 4 reads zero");
    a_brk_level: assert property (
        taken && wb_we_i && wb_sel_i[1] && wb_adr_i[5:2] == IDX_PRIO_0 |-> ##2
        (global_int_off_o || debug_breakpoint_level_o == $past(wb_dat_i[13:12], 2)))
        else $error("breakpoint level wrong");
    a_pwm_level: assert property (
        taken && wb_we_i && wb_sel_i[1] && wb_adr_i[5:2] == IDX_PRIO_9 |-> ##2
        (global_int_off_o || pwm_a_fault_level_o == map3($past(wb_dat_i[15:14], 2))))
        else $error("pwm a fault level wrong");
    a_nest_capture: assert property (
        isr_enter_i |-> ##2 min_nest_level_o == (4'hf << $past(isr_nest_level_i, 2)))
        else $error("nest level not captured");
    a_off_blocks: assert property (
        global_int_off_o |-> !ext_int_a_req_o && !ext_int_b_req_o
        && pwm_a_fault_level_o == 3'h0)
        else $error("request while disabled");
    a_pin_b_level: assert property (
        (low_power_i && !ext_int_b_pin_i && !global_int_off_o) [*4] |-> ext_int_b_req_o)
        else $error("low power level request missing");
    c_enter: cover property (isr_enter_i);
    c_off: cover property (global_int_off_o && wb_ack_o);
    c_lp_req: cover property (ext_int_b_req_o && low_power_i);
endmodule : int_prio_chk
bind interrupt_priority_control int_prio_chk i_int_prio_chk (.*);
`default_nettype wire

// *** test/core_model.sv ***
// core model: takes pin requests and enters service routines
`timescale 1ns/1ns
`default_nettype none
module core_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic req_a_i,
    input wire logic req_b_i,
    input wire logic slow_i,
    output logic isr_enter_o,
    output logic [1:0] isr_nest_level_o,
    output logic [6:0] isr_vector_o
);
    int wait_cnt;
    // a busy gap after each entry keeps entries apart, as a real core would
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            isr_enter_o <= 1'b0;
            isr_nest_level_o <= 2'h0;
            isr_vector_o <= 7'h00;
            wait_cnt <= 0;
        end else begin
            isr_enter_o <= 1'b0;
            if (wait_cnt > 0) begin
                wait_cnt <= wait_cnt - 1;
            end else if (req_a_i || req_b_i) begin
                isr_enter_o <= 1'b1;
                isr_nest_level_o <= isr_nest_level_o + 2'h1;
                isr_vector_o <= req_a_i ? 7'h08 : 7'h09;
                wait_cnt <= slow_i ? 12 : 3;
            end
        end
    end
endmodule : core_model
`default_nettype wire

// *** test/test_interrupt_priority_control.sv ***
// testbench: register map, levels, capture, pin sensing and event interrupt
`timescale 1ns/1ns
`default_nettype none
module test_interrupt_priority_control;
    import int_prio_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [5:0] wb_adr_i = 6'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic ext_int_a_pin_i = 1'b1;
    logic ext_int_b_pin_i = 1'b1;
    logic low_power_i = 1'b0;
    logic slow = 1'b0;
    wire logic [31:0] wb_dat_o;
    wire logic wb_ack_o, isr_enter_i, ext_int_a_req_o, ext_int_b_req_o, global_int_off_o, irq_o;
    wire logic [1:0] isr_nest_level_i, debug_breakpoint_level_o, debug_step_level_o;
    wire logic [1:0] debug_rx_level_o, debug_tx_level_o, trace_buffer_level_o;
    wire logic [2:0] timer_a_ch2_level_o, timer_a_ch1_level_o;
    wire logic [2:0] pwm_a_fault_level_o, pwm_b_fault_level_o;
    wire logic [3:0] min_nest_level_o;
    wire logic [6:0] isr_vector_i;
    int err_count = 0;
    int checks = 0;
    logic [15:0] prio [16] = '{default: 16'h0000};
    logic [15:0] q;
    logic [1:0] last_nest = 2'h0;
    logic [6:0] last_vec = 7'h00;
    logic [5:0] adrs [5] = '{6'h00, 6'h04, 6'h24, 6'h30, 6'h3c};
    always #5 clk_i = ~clk_i;
    interrupt_priority_control i_interrupt_priority_control (.*);
    core_model i_core_model (.clk_i(clk_i), .rst_i(rst_i), .req_a_i(ext_int_a_req_o),
        .req_b_i(ext_int_b_req_o), .slow_i(slow), .isr_enter_o(isr_enter_i),
        .isr_nest_level_o(isr_nest_level_i), .isr_vector_o(isr_vector_i));
    always @(posedge clk_i) if (isr_enter_i) begin
        last_nest = isr_nest_level_i;
        last_vec = isr_vector_i;
    end
    // ==========================================
    // tasks
    task automatic final_report();
        if (err_count == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    function automatic logic [2:0] map3(input logic [1:0] c);
        return (c == 2'h0) ? 3'h0 : {1'b1, c - 2'h1};
    endfunction : map3
    task automatic wb(input logic we, input logic [5:0] adr, input logic [15:0] d,
                      input logic [3:0] sel, output logic [15:0] r);
        int n;
        n = 0;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i} <= {2'b11, we, adr, sel};
        wb_dat_i <= {16'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        r = wb_dat_o[15:0];
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
        if (n >= 20) chk(16'h1, 16'h0);
    endtask : wb
    task automatic wr(input logic [5:0] adr, input logic [15:0] d, input logic [3:0] sel);
        logic [15:0] m;
        wb(1'b1, adr, d, sel, q);
        m = {{8{sel[1]}}, {8{sel[0]}}};
        case (adr[5:2])
            IDX_PRIO_0: m &= PRIO_0_WMASK;
            IDX_PRIO_1: m &= PRIO_1_WMASK;
            IDX_PRIO_9: m &= PRIO_9_WMASK;
            IDX_CTRL: m &= {16{sel[0]}} & 16'h0023;
            IDX_EVT_MASK: m &= {16{sel[0]}} & 16'h0007;
            default: m = 16'h0;
        endcase
        prio[adr[5:2]] = (prio[adr[5:2]] & ~m) | (d & m);
    endtask : wr
    task automatic rd(input logic [5:0] adr);
        wb(1'b0, adr, 16'h0, 4'hf, q);
        if (adr[5:2] == IDX_CTRL) begin
            chk(q, {1'b0, last_nest, last_vec, prio[12][5], 1'b1, ext_int_b_pin_i,
                    ext_int_a_pin_i, prio[12][1:0]});
            chk({12'h0, min_nest_level_o}, {12'h0, 4'hf << last_nest});
        end else chk(q, prio[adr[5:2]]);
    endtask : rd
    task automatic lvl_chk();
        logic off;
        repeat (2) @(posedge clk_i);
        off = prio[12][5];
        chk({15'h0, global_int_off_o}, {15'h0, off});
        chk({12'h0, debug_breakpoint_level_o, debug_step_level_o},
            off ? 16'h0 : {12'h0, prio[0][13:10]});
        chk({10'h0, debug_rx_level_o, debug_tx_level_o, trace_buffer_level_o},
            off ? 16'h0 : {10'h0, prio[1][5:0]});
        chk({10'h0, pwm_a_fault_level_o, pwm_b_fault_level_o}, off ? 16'h0 :
            {10'h0, map3(prio[9][15:14]), map3(prio[9][13:12])});
        chk({10'h0, timer_a_ch2_level_o, timer_a_ch1_level_o}, off ? 16'h0 :
            {10'h0, map3(prio[9][3:2]), map3(prio[9][1:0])});
    endtask : lvl_chk
    // ==========================================
    // main sequence
    initial begin
        void'($urandom(36075));
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 16; i++) if (i != 13) rd(6'(i * 4));
        repeat (16) begin
            wr(adrs[$urandom_range(4)], 16'($urandom), 4'($urandom));
            for (int i = 0; i < 5; i++) rd(adrs[i]);
            lvl_chk();
        end
        wr(6'h30, 16'h0000, 4'h1);
        for (int c = 0; c < 4; c++) begin
            wr(6'h24, {c[1:0], c[1:0], 8'h0, c[1:0], c[1:0]}, 4'h3);
            wr(6'h00, {2'h0, c[1:0], c[1:0], 10'h0}, 4'h3);
            lvl_chk();
        end
        wr(6'h38, 16'h0000, 4'h1);
        ext_int_a_pin_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        ext_int_a_pin_i <= 1'b1;
        repeat (20) @(posedge clk_i);
        wb(1'b0, 6'h34, 16'h0, 4'hf, q);
        chk(q, 16'h0005);
        chk({15'h0, irq_o}, 16'h0);
        wr(6'h38, 16'h0001, 4'h1);
        repeat (3) @(posedge clk_i);
        chk({15'h0, irq_o}, 16'h1);
        wb(1'b1, 6'h34, 16'h0007, 4'h1, q);
        repeat (3) @(posedge clk_i);
        chk({15'h0, irq_o}, 16'h0);
        wb(1'b0, 6'h34, 16'h0, 4'hf, q);
        chk(q, 16'h0000);
        rd(6'h30);
        slow <= 1'b1;
        wr(6'h30, 16'h0002, 4'h1);
        low_power_i <= 1'b1;
        ext_int_b_pin_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        chk({15'h0, ext_int_b_req_o}, 16'h1);
        low_power_i <= 1'b0;
        repeat (30) @(posedge clk_i);
        chk({15'h0, ext_int_b_req_o}, 16'h0);
        rd(6'h30);
        ext_int_b_pin_i <= 1'b1;
        wr(6'h30, 16'h0020, 4'h1);
        ext_int_a_pin_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        chk({15'h0, ext_int_a_req_o}, 16'h0);
        ext_int_a_pin_i <= 1'b1;
        lvl_chk();
        final_report();
    end
    initial begin
        #100000;
        err_count++;
        final_report();
    end
endmodule : test_interrupt_priority_control
`default_nettype wire
